// [include/ebw_defs.vh]
`ifndef EBW_DEFS_VH
`define EBW_DEFS_VH

`define EBW_AW               16
`define EBW_DW               16
`define EBW_WS_W             3
`define EBW_PERIPH_LO        16'h7000
`define EBW_PERIPH_HI        16'h7fff
`define EBW_DATA_EXT_LO      16'h8000
`define EBW_FIFO_W           35
`define EBW_FIFO_D           8
`define EBW_FIFO_AW          3
`define EBW_SP_PROG          2'h0
`define EBW_SP_DATA          2'h1
`define EBW_SP_IO            2'h2
`define EBW_WR_MIN_CYC       3'h1
`define EBW_ZERO3            3'h0
`define EBW_ONE3             3'h1
`define EBW_CLK_DIV          1'h1

`endif

// [logic/ebw_fifo.v]
`timescale 1ns/100ps
module ebw_fifo #(
  parameter WIDTH = 35,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             sys_clk,   // Clock
  input  wire             rstn,      // Sync reset, active low
  input  wire [WIDTH-1:0] in_data,   // Write data
  input  wire             in_valid,  // Write request
  output wire             in_ready,  // Not full
  output wire [WIDTH-1:0] out_data,  // Head entry
  output wire             out_valid, // Not empty
  input  wire             out_ready  // Pop
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr_reg;
  reg [AW-1:0]    rptr_reg;
  reg [AW:0]      cnt_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_reg != DEPTH);
  assign out_valid = (cnt_reg != 0);
  assign out_data  = mem[rptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge sys_clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      cnt_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// [logic/ebw_bus_if.v]
`timescale 1ns/100ps
`include "ebw_defs.vh"
// Operation
// - Address 64K sixteen-bit words in each of program, data and I/O spaces.
// - Multiplex all external CPU bus requests onto one external address and data bus.
// - Same-cycle requests run data write, then data read, then program fetch.
// - Buses are 16 bits; each access asserts only its own space select.
// - Data addresses 7000-7fff stay internal; only 8000-ffff goes external.
// - Addresses served by enabled on-chip memory make no external cycle.
// - I/O accesses use the same buses and sequence, only I/O select differs.
// - Direction output shows read or write for every external cycle.
// - Strobe output marks timing of every external read or write cycle.
// - Separate active-low read enable and write enable during their cycles.
// - Zero wait states gives single-cycle external reads.
// - Writes last at least two cycles; data bus turnaround delayed one full cycle.
// - Each wait state adds exactly one clock-output cycle, on boundaries.
// - Ready held low stretches the access until ready asserts.
// - Ready ignored for internal accesses; affects only external cycles.
// - On-chip generator inserts programmable zero to seven wait states.
// - No global memory space; global allocation register is reserved.
// - With ready low, wait one cycle, sample ready again, then continue.
// - Generator count is per space and applies whatever ready does.
module ebw_bus_if (
  input  wire                  sys_clk,            // 20 MHz clock
  input  wire                  rstn,               // Sync reset, active low
  input  wire                  dwr_req,            // CPU data write request
  input  wire [`EBW_AW-1:0]    dwr_addr,           // Data write address
  input  wire [`EBW_DW-1:0]    dwr_data,           // Data write value
  input  wire                  dwr_io,             // Write targets I/O space
  input  wire                  drd_req,            // CPU data read request
  input  wire [`EBW_AW-1:0]    drd_addr,           // Data read address
  input  wire                  drd_io,             // Read targets I/O space
  input  wire                  pf_req,             // CPU program fetch request
  input  wire [`EBW_AW-1:0]    pf_addr,            // Fetch address
  input  wire                  prog_onchip_hit,    // Fetch served by on-chip memory
  input  wire                  data_onchip_hit_wr, // Write served by on-chip memory
  input  wire                  data_onchip_hit_rd, // Read served by on-chip memory
  output wire                  req_ready,          // Request set accepted
  input  wire [`EBW_WS_W-1:0]  ws_prog,            // Wait states, program space
  input  wire [`EBW_WS_W-1:0]  ws_data,            // Wait states, data space
  input  wire [`EBW_WS_W-1:0]  ws_io,              // Wait states, I/O space
  output reg                   rd_done,            // Read data valid pulse
  output reg  [`EBW_DW-1:0]    rd_data,            // Read data
  output reg                   rd_is_fetch,        // Read was a program fetch
  output reg                   wr_done,            // Write finished pulse
  output reg                   clock_output,       // Bus timing clock
  output reg  [`EBW_AW-1:0]    ext_addr,           // External address bus
  output reg  [`EBW_DW-1:0]    ext_data_out,       // External data out
  output reg                   ext_data_oe,        // Data bus drive enable
  input  wire [`EBW_DW-1:0]    ext_data_in,        // External data in
  output reg                   program_space_sel_n,// Program space select
  output reg                   data_space_sel_n,   // Data space select
  output reg                   io_space_sel_n,     // I/O space select
  output reg                   rd_wr_n,            // High read, low write
  output reg                   bus_cycle_strobe_n, // Cycle strobe
  output reg                   rd_en_n,            // Read enable
  output reg                   wr_en_n,            // Write enable
  input  wire                  ready               // External ready pin
);
  localparam ST_IDLE = 2'h0;
  localparam ST_ACC  = 2'h1;
  localparam ST_WR2  = 2'h2;
  localparam ST_WAIT = 2'h3;
  // No global space decoded; its allocation register is left reserved

  reg  [1:0]            state_reg;
  reg  [`EBW_WS_W-1:0]  ws_cnt_reg;
  reg                   rdy_s1_reg;
  reg                   rdy_s2_reg;
  wire [`EBW_FIFO_W-1:0] f_head;
  wire                  f_valid;
  reg                   f_pop;
  reg  [`EBW_FIFO_W-1:0] f_in;
  reg                   f_in_valid;
  wire                  f_in_ready;
  reg  [2:0]            pend_reg;
  reg  [2:0]            pend_next;
  wire                  wr_ext;
  wire                  rd_ext;
  wire                  pf_ext;
  wire                  h_wr;
  wire [1:0]            h_sp;
  wire [`EBW_AW-1:0]    h_addr;
  wire [`EBW_DW-1:0]    h_data;
  reg  [`EBW_WS_W-1:0]  h_ws;
  reg  [2:0]            pend_left;
  reg                   bus_ce_reg;

  // Peripheral window never leaves the chip
  // Internal hits never queue, so ready never reaches them
  assign wr_ext = dwr_req && !data_onchip_hit_wr &&
                  (dwr_io || dwr_addr >= `EBW_DATA_EXT_LO);
  assign rd_ext = drd_req && !data_onchip_hit_rd &&
                  (drd_io || drd_addr >= `EBW_DATA_EXT_LO);
  assign pf_ext = pf_req && !prog_onchip_hit;
  // Set counts as taken only once its last entry is queued
  assign req_ready = f_in_ready ? (pend_left == 3'h0) : (pend_next == 3'h0);

  // Entry: {wr, space[1:0], addr, data}
  always @* begin
    pend_next  = pend_reg;
    f_in       = {`EBW_FIFO_W{1'b0}};
    f_in_valid = 1'b0;
    pend_left  = 3'h0;
    if (pend_reg == 3'h0) begin
      pend_next = {wr_ext, rd_ext, pf_ext};
    end
    if (pend_next[2]) begin
      f_in = {1'b1, (dwr_io ? `EBW_SP_IO : `EBW_SP_DATA), dwr_addr, dwr_data};
      f_in_valid = 1'b1;
      pend_left  = {1'b0, pend_next[1:0]};
    end else if (pend_next[1]) begin
      f_in = {1'b0, (drd_io ? `EBW_SP_IO : `EBW_SP_DATA), drd_addr, {`EBW_DW{1'b0}}};
      f_in_valid = 1'b1;
      pend_left  = {2'b00, pend_next[0]};
    end else if (pend_next[0]) begin
      f_in = {1'b0, `EBW_SP_PROG, pf_addr, {`EBW_DW{1'b0}}};
      f_in_valid = 1'b1;
    end
  end

  // Request inputs must stay stable until req_ready
  always @(posedge sys_clk) begin
    if (!rstn) begin
      pend_reg <= 3'h0;
    end else if (f_in_valid && f_in_ready) begin
      if (pend_next[2]) begin
        pend_reg <= {1'b0, pend_next[1:0]};
      end else if (pend_next[1]) begin
        pend_reg <= {2'b00, pend_next[0]};
      end else begin
        pend_reg <= 3'h0;
      end
    end else begin
      pend_reg <= pend_next;
    end
  end

  ebw_fifo #(
    .WIDTH (`EBW_FIFO_W),
    .DEPTH (`EBW_FIFO_D),
    .AW    (`EBW_FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_data   (f_in),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_head),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  assign h_wr   = f_head[`EBW_FIFO_W-1];
  assign h_sp   = f_head[`EBW_FIFO_W-2:`EBW_FIFO_W-3];
  assign h_addr = f_head[`EBW_AW+`EBW_DW-1:`EBW_DW];
  assign h_data = f_head[`EBW_DW-1:0];

  always @* begin
    case (h_sp)
      `EBW_SP_PROG: h_ws = ws_prog;
      `EBW_SP_DATA: h_ws = ws_data;
      `EBW_SP_IO:   h_ws = ws_io;
      default:      h_ws = `EBW_ZERO3;
    endcase
  end

  // Pin is asynchronous to the core clock
  always @(posedge sys_clk) begin
    if (!rstn) begin
      rdy_s1_reg <= 1'b1;
      rdy_s2_reg <= 1'b1;
    end else begin
      rdy_s1_reg <= ready;
      rdy_s2_reg <= rdy_s1_reg;
    end
  end

  // One enable pulse per clock_output period paces the bus
  always @(posedge sys_clk) begin
    if (!rstn) begin
      bus_ce_reg <= 1'b0;
    end else begin
      bus_ce_reg <= ~bus_ce_reg;
    end
  end

  always @* begin
    f_pop = 1'b0;
    if (bus_ce_reg && ((state_reg == ST_ACC && !h_wr) || state_reg == ST_WR2)) begin
      f_pop = (ws_cnt_reg == `EBW_ZERO3) && rdy_s2_reg;
    end
  end

  always @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg           <= ST_IDLE;
      ws_cnt_reg          <= `EBW_ZERO3;
      clock_output        <= 1'b0;
      ext_addr            <= {`EBW_AW{1'b0}};
      ext_data_out        <= {`EBW_DW{1'b0}};
      ext_data_oe         <= 1'b0;
      program_space_sel_n <= 1'b1;
      data_space_sel_n    <= 1'b1;
      io_space_sel_n      <= 1'b1;
      rd_wr_n             <= 1'b1;
      bus_cycle_strobe_n  <= 1'b1;
      rd_en_n             <= 1'b1;
      wr_en_n             <= 1'b1;
      rd_done             <= 1'b0;
      rd_data             <= {`EBW_DW{1'b0}};
      rd_is_fetch         <= 1'b0;
      wr_done             <= 1'b0;
    end else begin
      clock_output <= ~clock_output;
      rd_done      <= 1'b0;
      wr_done      <= 1'b0;
      // Bus steps and wait states last one whole clock_output period
      if (bus_ce_reg) begin
        case (state_reg)
          ST_IDLE: begin
            program_space_sel_n <= 1'b1;
            data_space_sel_n    <= 1'b1;
            io_space_sel_n      <= 1'b1;
            bus_cycle_strobe_n  <= 1'b1;
            rd_en_n             <= 1'b1;
            wr_en_n             <= 1'b1;
            rd_wr_n             <= 1'b1;
            ext_data_oe         <= 1'b0;
            if (f_valid) begin
              ext_addr            <= h_addr;
              program_space_sel_n <= (h_sp != `EBW_SP_PROG);
              data_space_sel_n    <= (h_sp != `EBW_SP_DATA);
              io_space_sel_n      <= (h_sp != `EBW_SP_IO);
              rd_wr_n             <= !h_wr;
              bus_cycle_strobe_n  <= 1'b0;
              rd_en_n             <= h_wr;
              ws_cnt_reg          <= h_ws;
              ext_data_out        <= h_data;
              state_reg           <= ST_ACC;
            end
          end
          ST_ACC: begin
            if (h_wr) begin
              // Data drive starts one whole clock_output period in to avoid contention
              ext_data_oe <= 1'b1;
              wr_en_n     <= 1'b0;
              state_reg   <= ST_WR2;
            end else if (ws_cnt_reg != `EBW_ZERO3) begin
              ws_cnt_reg <= ws_cnt_reg - `EBW_ONE3;
            end else if (!rdy_s2_reg) begin
              state_reg <= ST_WAIT;
            end else begin
              rd_data             <= ext_data_in;
              rd_done             <= 1'b1;
              rd_is_fetch         <= (h_sp == `EBW_SP_PROG);
              // Selects drop with the strobe so the gap is fully idle
              program_space_sel_n <= 1'b1;
              data_space_sel_n    <= 1'b1;
              io_space_sel_n      <= 1'b1;
              bus_cycle_strobe_n  <= 1'b1;
              rd_en_n             <= 1'b1;
              state_reg           <= ST_IDLE;
            end
          end
          ST_WR2: begin
            if (ws_cnt_reg != `EBW_ZERO3) begin
              ws_cnt_reg <= ws_cnt_reg - `EBW_ONE3;
            end else if (!rdy_s2_reg) begin
              state_reg <= ST_WAIT;
            end else begin
              wr_done             <= 1'b1;
              wr_en_n             <= 1'b1;
              bus_cycle_strobe_n  <= 1'b1;
              program_space_sel_n <= 1'b1;
              data_space_sel_n    <= 1'b1;
              io_space_sel_n      <= 1'b1;
              rd_wr_n             <= 1'b1;
              // Drive ends with the strobe, a period before any read
              ext_data_oe         <= 1'b0;
              state_reg           <= ST_IDLE;
            end
          end
          ST_WAIT: begin
            // Re-check ready one cycle later
            if (rdy_s2_reg) begin
              state_reg <= h_wr ? ST_WR2 : ST_ACC;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// [testbench/ebw_bus_if_assertions.sv]
`timescale 1ns/100ps
module ebw_chk (
  input wire        sys_clk,             // Clock
  input wire        rstn,                // Sync reset
  input wire [15:0] ext_addr,            // Address bus
  input wire        ext_data_oe,         // Data drive
  input wire        program_space_sel_n, // Program select
  input wire        data_space_sel_n,    // Data select
  input wire        io_space_sel_n,      // I/O select
  input wire        rd_wr_n,             // Direction
  input wire        bus_cycle_strobe_n,  // Strobe
  input wire        rd_en_n,             // Read enable
  input wire        wr_en_n,             // Write enable
  input wire        rd_done,             // Read done
  input wire        wr_done,             // Write done
  input wire        clock_output         // Bus clock
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_sel; !bus_cycle_strobe_n |->
    $onehot({~program_space_sel_n, ~data_space_sel_n, ~io_space_sel_n}); endproperty
  a_sel: assert property (p_sel) else $error("space select not unique");
  property p_idle; bus_cycle_strobe_n |-> rd_en_n && wr_en_n; endproperty
  a_idle: assert property (p_idle) else $error("enable outside strobe");
  property p_rd; !rd_en_n |-> rd_wr_n && !ext_data_oe; endproperty
  a_rd: assert property (p_rd) else $error("read with bus driven");
  property p_wr; !wr_en_n |-> !rd_wr_n && ext_data_oe; endproperty
  a_wr: assert property (p_wr) else $error("write direction wrong");
  property p_dsp; !data_space_sel_n |-> ext_addr[15]; endproperty
  a_dsp: assert property (p_dsp) else $error("low data address external");
  property p_wlen; $fell(bus_cycle_strobe_n) && !rd_wr_n |=> !bus_cycle_strobe_n [*3];
  endproperty
  a_wlen: assert property (p_wlen) else $error("write shorter than two");
  property p_gap; $rose(bus_cycle_strobe_n) |-> program_space_sel_n && data_space_sel_n &&
    io_space_sel_n && rd_en_n && wr_en_n; endproperty
  a_gap: assert property (p_gap) else $error("no idle cycle");
  property p_hold; !bus_cycle_strobe_n && !$fell(bus_cycle_strobe_n) |->
    $stable(ext_addr) && $stable(rd_wr_n); endproperty
  a_hold: assert property (p_hold) else $error("address moved in cycle");
  property p_rdd; rd_done |-> $past(rd_en_n) == 1'h0; endproperty
  a_rdd: assert property (p_rdd) else $error("read done without read");
  property p_wrd; wr_done |-> $past(wr_en_n) == 1'h0; endproperty
  a_wrd: assert property (p_wrd) else $error("write done without write");
  property p_clk; $past(rstn) |-> clock_output != $past(clock_output); endproperty
  a_clk: assert property (p_clk) else $error("bus clock stuck");
  property p_end; $fell(bus_cycle_strobe_n) && rd_wr_n |-> ##[1:40] rd_done; endproperty
  a_end: assert property (p_end) else $error("read never ends");
endmodule
bind ebw_bus_if ebw_chk ebw_chk_i (.sys_clk, .rstn, .ext_addr, .ext_data_oe,
  .program_space_sel_n, .data_space_sel_n, .io_space_sel_n, .rd_wr_n,
  .bus_cycle_strobe_n, .rd_en_n, .wr_en_n, .rd_done, .wr_done, .clock_output);

// [testbench/ebw_mem_model.sv]
`timescale 1ns/100ps
module ebw_mem_model (
  input wire         sys_clk,             // Clock
  input wire  [15:0] ext_addr,            // Address bus
  input wire  [15:0] ext_data_out,        // Write data
  input wire         ext_data_oe,         // Device drives bus
  input wire         program_space_sel_n, // Program select
  input wire         data_space_sel_n,    // Data select
  input wire         rd_en_n,             // Read enable
  input wire         wr_en_n,             // Write enable
  input wire         stall,               // Hold ready low
  output wire [15:0] ext_data_in,         // Read data
  output wire        ready                // Ready pin
);
  logic [15:0] mem [0:63];
  logic [15:0] last = 16'h0;
  wire  [1:0]  sp = !program_space_sel_n ? 2'h0 : !data_space_sel_n ? 2'h1 : 2'h2;
  wire  [5:0]  key = {sp, ext_addr[3:0]};
  integer i;
  initial for (i = 0; i < 64; i = i + 1) mem[i] = 16'h5a00 + i[15:0];
  // Released bus shows the inverse of the last word, never a stale copy
  assign ext_data_in = !rd_en_n ? mem[key] : ~last;
  assign ready = !stall;
  always @(posedge sys_clk) begin
    if (!wr_en_n && ext_data_oe) mem[key] <= ext_data_out;
    if (!rd_en_n) last <= mem[key];
  end
endmodule

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb;
  logic        sys_clk = 1'h0, rstn = 1'h0, stall = 1'h0;
  logic        dwr_req = 1'h0, dwr_io = 1'h0, drd_req = 1'h0, drd_io = 1'h0, pf_req = 1'h0;
  logic [15:0] dwr_addr = 16'h0, dwr_data = 16'h0, drd_addr = 16'h0, pf_addr = 16'h0;
  logic        prog_onchip_hit = 1'h0, data_onchip_hit_wr = 1'h0, data_onchip_hit_rd = 1'h0;
  logic [2:0]  ws_prog = 3'h0, ws_data = 3'h0, ws_io = 3'h0;
  wire         req_ready, rd_done, rd_is_fetch, wr_done, clock_output, ext_data_oe, ready;
  wire         program_space_sel_n, data_space_sel_n, io_space_sel_n, rd_wr_n;
  wire         bus_cycle_strobe_n, rd_en_n, wr_en_n;
  wire  [15:0] rd_data, ext_addr, ext_data_out, ext_data_in;
  integer      fails = 0, n_compared = 0, cnt = 0, slen = 0, nstb = 0, k;
  ebw_bus_if ebw_bus_if_i (.sys_clk, .rstn, .dwr_req, .dwr_addr, .dwr_data, .dwr_io,
    .drd_req, .drd_addr, .drd_io, .pf_req, .pf_addr, .prog_onchip_hit, .data_onchip_hit_wr,
    .data_onchip_hit_rd, .req_ready, .ws_prog, .ws_data, .ws_io, .rd_done, .rd_data,
    .rd_is_fetch, .wr_done, .clock_output, .ext_addr, .ext_data_out, .ext_data_oe,
    .ext_data_in, .program_space_sel_n, .data_space_sel_n, .io_space_sel_n, .rd_wr_n,
    .bus_cycle_strobe_n, .rd_en_n, .wr_en_n, .ready);
  ebw_mem_model ebw_mem_model_i (.sys_clk, .ext_addr, .ext_data_out, .ext_data_oe,
    .program_space_sel_n, .data_space_sel_n, .rd_en_n, .wr_en_n, .stall, .ext_data_in, .ready);
  initial forever #25 sys_clk = ~sys_clk;
  // Length of the last strobe-low run, in clocks
  always @(posedge sys_clk) begin
    if (bus_cycle_strobe_n === 1'h0) cnt <= cnt + 1;
    else if (cnt != 0) begin
      slen <= cnt;
      cnt <= 0;
      nstb <= nstb + 1;
    end
  end
  task conclude;
    begin
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        $display("Error at %0t: got %h exp %h", $time, got, exp);
        fails = fails + 1;
      end
    end
  endtask
  task to;
    begin
      fails = fails + 1;
      $display("Error at %0t: wait ran out", $time);
      conclude;
    end
  endtask
  // Holds the request set until an edge takes it
  task go;
    integer i;
    begin
      for (i = 0; i < 50; i = i + 1) begin
        #1;
        if (req_ready === 1'h1) i = 99;
        else @(negedge sys_clk);
      end
      if (i == 50) to;
      @(negedge sys_clk);
      dwr_req = 1'h0; drd_req = 1'h0; pf_req = 1'h0; dwr_io = 1'h0; drd_io = 1'h0;
    end
  endtask
  task wt(input logic w, input logic [15:0] d, input logic f);
    integer i;
    begin
      for (i = 0; i < 80 && rd_done !== 1'h1 && wr_done !== 1'h1; i = i + 1)
        @(negedge sys_clk);
      if (i == 80) to;
      if (w) chk({31'h0, wr_done}, 32'h1);
      else chk({14'h0, rd_done, rd_is_fetch, rd_data}, {14'h0, 1'h1, f, d});
      @(negedge sys_clk);
    end
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    chk({24'h0, program_space_sel_n, data_space_sel_n, io_space_sel_n, bus_cycle_strobe_n,
      rd_en_n, wr_en_n, rd_wr_n, ext_data_oe}, 32'hfe);
    rstn = 1'h1;
    $display("reset test done");
    dwr_req = 1'h1; dwr_addr = 16'h8003; dwr_data = 16'hbeef;
    drd_req = 1'h1; drd_addr = 16'h8003; pf_req = 1'h1; pf_addr = 16'h0007;
    go;
    wt(1'h1, 16'h0, 1'h0);
    wt(1'h0, 16'hbeef, 1'h0);
    wt(1'h0, 16'h5a07, 1'h1);
    $display("order test done");
    dwr_req = 1'h1; dwr_io = 1'h1; dwr_addr = 16'h0005; dwr_data = 16'h2222;
    go;
    wt(1'h1, 16'h0, 1'h0);
    drd_req = 1'h1; drd_io = 1'h1; drd_addr = 16'h0005;
    go;
    wt(1'h0, 16'h2222, 1'h0);
    drd_req = 1'h1; drd_addr = 16'h8005;
    go;
    wt(1'h0, 16'h5a15, 1'h0);
    $display("io test done");
    stall = 1'h1;
    dwr_req = 1'h1; dwr_addr = 16'h7010; drd_req = 1'h1; drd_addr = 16'h7020;
    pf_req = 1'h1; prog_onchip_hit = 1'h1;
    go;
    dwr_req = 1'h1; dwr_addr = 16'h9000; data_onchip_hit_wr = 1'h1;
    drd_req = 1'h1; drd_addr = 16'h9001; data_onchip_hit_rd = 1'h1;
    go;
    k = nstb;
    repeat (20) @(negedge sys_clk);
    chk(nstb, k);
    prog_onchip_hit = 1'h0; data_onchip_hit_wr = 1'h0; data_onchip_hit_rd = 1'h0; stall = 1'h0;
    $display("internal test done");
    for (k = 0; k < 8; k = k + 1) begin
      ws_data = k[2:0]; ws_io = 3'h7 - k[2:0]; ws_prog = 3'h7;
      dwr_req = 1'h1; dwr_addr = 16'h8010 + k[15:0]; dwr_data = 16'h3c00 + k[15:0];
      go;
      wt(1'h1, 16'h0, 1'h0);
      chk(slen, 4 + 2 * k);
      drd_req = 1'h1; drd_addr = 16'h8010 + k[15:0];
      go;
      wt(1'h0, 16'h3c00 + k[15:0], 1'h0);
      chk(slen, 2 + 2 * k);
    end
    pf_req = 1'h1; pf_addr = 16'h0002; ws_io = 3'h3;
    go;
    wt(1'h0, 16'h5a02, 1'h1);
    chk(slen, 16);
    drd_req = 1'h1; drd_io = 1'h1; drd_addr = 16'h0005;
    go;
    wt(1'h0, 16'h2222, 1'h0);
    chk(slen, 8);
    $display("wait state test done");
    ws_data = 3'h1; stall = 1'h1; drd_req = 1'h1; drd_addr = 16'h8013;
    go;
    repeat (6) @(negedge sys_clk);
    stall = 1'h0;
    wt(1'h0, 16'h3c03, 1'h0);
    chk({31'h0, slen > 4}, 32'h1);
    $display("ready test done");
    conclude;
  end
endmodule
